// *** common/ipr_pkg.sv ***
// Constants, types and helpers for the first interrupt pin event router
package ipr_pkg;

	// ==================================================================
	// Register addresses
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h2A; // Software reset entry
	localparam logic [7:0] ADDR_MAP0_LOW   = 8'h2B; // Pin 0 routing, low map
	localparam logic [7:0] ADDR_MAP0_HIGH  = 8'h2C; // Pin 0 routing, high map
	localparam logic [7:0] ADDR_MAP1_LOW   = 8'h2D; // Pin 1 routing, low map

	// ==================================================================
	// Reset values and codes
	localparam logic [7:0] MAP0_LOW_RST    = 8'h80; // Busy routing on by default
	localparam logic [7:0] MAP0_HIGH_RST   = 8'h00; // All sources off
	localparam logic [7:0] MAP1_LOW_RST    = 8'h00; // All sources off
	localparam logic [7:0] SOFT_RESET_CODE = 8'h52; // Key that starts a soft reset
	localparam logic [7:0] RDATA_IDLE      = 8'h00; // Read value when nothing answers

	// ==================================================================
	// Field positions, low map
	localparam int unsigned POS_FUSE_BUSY  = 7;
	localparam int unsigned POS_IDLE       = 6;
	localparam int unsigned POS_MOTION     = 5;
	localparam int unsigned POS_LOW_RSVD   = 4;
	localparam int unsigned POS_Q_LEVEL    = 3;
	localparam int unsigned POS_Q_OVERFLOW = 2;
	localparam int unsigned POS_Q_FULL     = 1;
	localparam int unsigned POS_SAMPLE_RDY = 0;

	// Field positions, high map
	localparam int unsigned POS_FUSE_DONE  = 7;
	localparam int unsigned POS_FUSE_REQ   = 6;
	localparam int unsigned POS_UNDERVOLT  = 5;
	localparam int unsigned POS_CLIP       = 4;
	localparam int unsigned POS_PARITY     = 3;
	localparam int unsigned POS_TAP3       = 2;
	localparam int unsigned POS_TAP2       = 1;
	localparam int unsigned POS_TAP1       = 0;

	// Enable bits whose sense is inverted (zero enables)
	localparam logic [7:0] MAP_LOW_INV  = 8'h02;
	localparam logic [7:0] MAP_HIGH_INV = 8'h00;

	// ==================================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS     = 20;
	localparam int unsigned SOFT_RST_NS       = 500000;
	localparam int unsigned SOFT_RST_CYCLES   =
		(SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SOFT_RST_CNT_W    = 15;

	// ==================================================================
	// Soft reset sequencer states, Gray along run -> init -> hiz
	typedef enum logic [1:0] {
		ST_RUN  = 2'h0,
		ST_INIT = 2'h1,
		ST_HIZ  = 2'h3
	} ipr_state_t;

	// ==================================================================
	// Qualify a source byte with its map, honouring inverted enables
	function automatic logic ipr_qualify(
		input logic [7:0] map,
		input logic [7:0] src,
		input logic [7:0] inv
	);
		ipr_qualify = |(src & (map ^ inv));
	endfunction : ipr_qualify

endpackage : ipr_pkg

// *** common/ipr_route_if.sv ***
// Map and source bundle between the register side and the routing logic
`timescale 1ns/1ps
`default_nettype none

interface ipr_route_if;
	logic [7:0] map_low;  // Low routing map
	logic [7:0] map_high; // High routing map
	logic [7:0] src_low;  // Sources matching the low map
	logic [7:0] src_high; // Sources matching the high map
	logic       hit;      // Any qualified source active

	modport regs (output map_low, output map_high, output src_low,
		output src_high, input hit);
	modport route (input map_low, input map_high, input src_low,
		input src_high, output hit);
endinterface : ipr_route_if

`default_nettype wire

// *** verilog/ipr_route.sv ***
// Combines qualified sources into the first interrupt pin request
`timescale 1ns/1ps
`default_nettype none

module ipr_route
	import ipr_pkg::*;
(
	// Map and sources in, request out
	ipr_route_if.route bus
);

	// ==================================================================
	// Per-map qualification
	wire logic w_hit_low;  // Low map contributes
	wire logic w_hit_high; // High map contributes

	// Inverted sense of the full bit is folded in by the mask
	assign w_hit_low  = ipr_qualify(bus.map_low, bus.src_low, MAP_LOW_INV);
	assign w_hit_high = ipr_qualify(bus.map_high, bus.src_high, MAP_HIGH_INV);

	// Wired OR of every qualified source
	assign bus.hit = w_hit_low | w_hit_high;

endmodule : ipr_route

`default_nettype wire

// *** verilog/ipr_router.sv ***
// Top of the first interrupt pin event router with its map registers
`timescale 1ns/1ps
`default_nettype none

module ipr_router
	import ipr_pkg::*;
#(
	// Soft reset settle time; shorten for simulation
	parameter int unsigned P_SRST_CYCLES = SOFT_RST_CYCLES
) (
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output var  logic [7:0] o_rdata,
	// Event and status sources, low map
	input  wire logic       i_fuse_busy_status,
	input  wire logic       i_idle,
	input  wire logic       i_motion,
	input  wire logic       i_queue_level,
	input  wire logic       i_queue_overflow,
	input  wire logic       i_queue_full,
	input  wire logic       i_sample_ready,
	// Event and status sources, high map
	input  wire logic       i_fuse_done_status,
	input  wire logic       i_fuse_request,
	input  wire logic       i_undervolt_latched,
	input  wire logic       i_clip_latched,
	input  wire logic       i_parity_fault,
	input  wire logic       i_tap3,
	input  wire logic       i_tap2,
	input  wire logic       i_tap1,
	// Interrupt pins
	output var  logic       o_first_irq_pin,
	output var  logic       o_first_irq_pin_oe,
	output var  logic       o_second_irq_pin,
	output var  logic       o_second_irq_pin_oe,
	// Status
	output var  logic       o_soft_reset_busy
);

	// ==================================================================
	// Registers
	logic [7:0]                map0_low_reg;   // Pin 0 low routing map
	logic [7:0]                map0_high_reg;  // Pin 0 high routing map
	logic [7:0]                map1_low_reg;   // Pin 1 low map, stored only
	logic [7:0]                rdata_reg;      // Read data, one cycle late
	logic                      pin0_reg;       // Registered pin 0 level
	logic                      pin1_reg;       // Registered pin 1 level, held low
	logic                      oe_reg;         // Pins driven while set
	logic                      busy_reg;       // Soft reset settling
	logic [SOFT_RST_CNT_W-1:0] cnt_reg;        // Settle counter
	logic [SOFT_RST_CNT_W-1:0] cnt_next;       // Settle counter next
	ipr_state_t                state_reg;      // Sequencer state
	ipr_state_t                state_next;     // Sequencer next state

	// ==================================================================
	// Access decode
	wire logic w_sel_srst;   // Soft reset address
	wire logic w_sel_low;    // Low map address
	wire logic w_sel_high;   // High map address
	wire logic w_sel_pin1;   // Pin 1 map address
	wire logic w_in_init;    // Settling, map access locked
	wire logic w_wr_ok;      // Write may land in a map
	wire logic w_srst_req;   // Valid soft reset key written
	wire logic w_map_wr;     // Any map written
	wire logic w_cnt_done;   // Settle time elapsed

	assign w_sel_srst = (i_addr == ADDR_SOFT_RESET);
	assign w_sel_low  = (i_addr == ADDR_MAP0_LOW);
	assign w_sel_high = (i_addr == ADDR_MAP0_HIGH);
	assign w_sel_pin1 = (i_addr == ADDR_MAP1_LOW);
	assign w_in_init  = (state_reg == ST_INIT);
	assign w_wr_ok    = i_wr && !w_in_init;

	// Only the exact key starts a reset; other values are dropped
	assign w_srst_req = w_wr_ok && w_sel_srst && (i_wdata == SOFT_RESET_CODE);
	assign w_map_wr   = w_wr_ok && (w_sel_low || w_sel_high || w_sel_pin1);
	assign w_cnt_done = (cnt_reg == SOFT_RST_CNT_W'(P_SRST_CYCLES - 1));

	// ==================================================================
	// Read mux; during settling every read returns zero
	wire logic [7:0] w_rd_val;   // Addressed register value
	wire logic [7:0] w_rd_next;  // Value for the read data flop

	assign w_rd_val = w_sel_low  ? map0_low_reg  :
		w_sel_high ? map0_high_reg :
		w_sel_pin1 ? map1_low_reg  :
		RDATA_IDLE;
	assign w_rd_next = (i_rd && !w_in_init) ? w_rd_val : RDATA_IDLE;

	// ==================================================================
	// Source vectors laid out by enable position
	wire logic [7:0] w_src_low;   // Sources for the low map
	wire logic [7:0] w_src_high;  // Sources for the high map

	assign w_src_low[POS_FUSE_BUSY]  = i_fuse_busy_status;
	assign w_src_low[POS_IDLE]       = i_idle;
	assign w_src_low[POS_MOTION]     = i_motion;
	assign w_src_low[POS_LOW_RSVD]   = 1'b0;
	assign w_src_low[POS_Q_LEVEL]    = i_queue_level;
	assign w_src_low[POS_Q_OVERFLOW] = i_queue_overflow;
	assign w_src_low[POS_Q_FULL]     = i_queue_full;
	assign w_src_low[POS_SAMPLE_RDY] = i_sample_ready;
	assign w_src_high[POS_FUSE_DONE] = i_fuse_done_status;
	assign w_src_high[POS_FUSE_REQ]  = i_fuse_request;
	assign w_src_high[POS_UNDERVOLT] = i_undervolt_latched;
	assign w_src_high[POS_CLIP]      = i_clip_latched;
	assign w_src_high[POS_PARITY]    = i_parity_fault;
	assign w_src_high[POS_TAP3]      = i_tap3;
	assign w_src_high[POS_TAP2]      = i_tap2;
	assign w_src_high[POS_TAP1]      = i_tap1;

	// ==================================================================
	// Routing
	ipr_route_if route_bus ();

	assign route_bus.map_low  = map0_low_reg;
	assign route_bus.map_high = map0_high_reg;
	assign route_bus.src_low  = w_src_low;
	assign route_bus.src_high = w_src_high;

	ipr_route u_route (
		.bus (route_bus.route)
	);

	// ==================================================================
	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			// Normal operation, pins driven
			ST_RUN: begin
				if (w_srst_req) begin
					state_next = ST_INIT;
					cnt_next   = '0;
				end
			end
			// Settling, registers locked
			ST_INIT: begin
				cnt_next = cnt_reg + SOFT_RST_CNT_W'(1);
				if (w_cnt_done) begin
					state_next = ST_HIZ;
				end
			end
			// Pins float until software touches a map
			ST_HIZ: begin
				if (w_srst_req) begin
					state_next = ST_INIT;
					cnt_next   = '0;
				end else if (w_map_wr) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// Sequencer flops
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_reg <= ST_RUN;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// ==================================================================
	// Map registers; soft reset returns them to reset values
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || w_srst_req) begin
			map0_low_reg  <= MAP0_LOW_RST;
			map0_high_reg <= MAP0_HIGH_RST;
			map1_low_reg  <= MAP1_LOW_RST;
		end else begin
			if (w_wr_ok && w_sel_low) begin
				map0_low_reg <= i_wdata;
			end
			if (w_wr_ok && w_sel_high) begin
				map0_high_reg <= i_wdata;
			end
			if (w_wr_ok && w_sel_pin1) begin
				map1_low_reg <= i_wdata;
			end
		end
	end

	// ==================================================================
	// Output flops; level follows sources one cycle late
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rdata_reg <= RDATA_IDLE;
			pin0_reg  <= 1'b0;
			pin1_reg  <= 1'b0;
			oe_reg    <= 1'b1;
			busy_reg  <= 1'b0;
		end else begin
			rdata_reg <= w_rd_next;
			pin0_reg  <= route_bus.hit;
			// Pin 1 routing lives elsewhere, so its level stays low here
			pin1_reg  <= 1'b0;
			oe_reg    <= (state_next == ST_RUN);
			busy_reg  <= (state_next == ST_INIT);
		end
	end

	// Second pin has no sources here and idles low when driven
	assign o_rdata             = rdata_reg;
	assign o_first_irq_pin     = pin0_reg;
	assign o_first_irq_pin_oe  = oe_reg;
	assign o_second_irq_pin    = pin1_reg;
	assign o_second_irq_pin_oe = oe_reg;
	assign o_soft_reset_busy   = busy_reg;

	// ==================================================================
	// Checks
	sequence s_srst_key;
		i_wr && w_sel_srst && (i_wdata == SOFT_RESET_CODE) && !w_in_init;
	endsequence

	sequence s_locked;
		!o_first_irq_pin_oe && (map0_low_reg == MAP0_LOW_RST)
			&& (map0_high_reg == MAP0_HIGH_RST);
	endsequence

	property p_busy_route;
		@(posedge i_clk_sys) disable iff (i_reset)
		(map0_low_reg[7] && i_fuse_busy_status) |=> o_first_irq_pin;
	endproperty
	a_busy_route: assert property (p_busy_route)
		else $error("busy source not routed");

	property p_full_inverted;
		@(posedge i_clk_sys) disable iff (i_reset)
		(map0_low_reg == 8'h02 && map0_high_reg == 8'h00) |=> !o_first_irq_pin;
	endproperty
	a_full_inverted: assert property (p_full_inverted)
		else $error("full bit set must block all low sources");

	property p_full_enabled;
		@(posedge i_clk_sys) disable iff (i_reset)
		(!map0_low_reg[1] && i_queue_full) |=> o_first_irq_pin;
	endproperty
	a_full_enabled: assert property (p_full_enabled)
		else $error("full bit clear must route queue full");

	property p_tap1_route;
		@(posedge i_clk_sys) disable iff (i_reset)
		(map0_high_reg[0] && i_tap1) |=> o_first_irq_pin;
	endproperty
	a_tap1_route: assert property (p_tap1_route)
		else $error("single tap not routed");

	property p_none_quiet;
		@(posedge i_clk_sys) disable iff (i_reset)
		((w_src_low & (map0_low_reg ^ MAP_LOW_INV)) == 8'h00
			&& (w_src_high & map0_high_reg) == 8'h00) |=> !o_first_irq_pin;
	endproperty
	a_none_quiet: assert property (p_none_quiet)
		else $error("pin high with no qualified source");

	property p_reset_values;
		@(posedge i_clk_sys)
		i_reset |=> (map0_low_reg == 8'h80 && map0_high_reg == 8'h00
			&& map1_low_reg == 8'h00);
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("map reset values wrong");

	property p_read_high;
		@(posedge i_clk_sys) disable iff (i_reset)
		(i_rd && i_addr == 8'h2C && !w_in_init) |=> o_rdata == $past(map0_high_reg);
	endproperty
	a_read_high: assert property (p_read_high)
		else $error("high map read mismatch");

	property p_read_pin1;
		@(posedge i_clk_sys) disable iff (i_reset)
		(i_wr && i_addr == 8'h2D && !w_in_init) ##1 (i_rd && i_addr == 8'h2D && !i_wr)
			|=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_read_pin1: assert property (p_read_pin1)
		else $error("pin 1 map did not hold written value");

	property p_soft_reset;
		@(posedge i_clk_sys) disable iff (i_reset)
		s_srst_key |=> s_locked ##1 (o_soft_reset_busy && !o_first_irq_pin_oe);
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset did not clear maps and float pins");

	property p_hiz_hold;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg == ST_HIZ && !w_map_wr && !w_srst_req) |=> !o_first_irq_pin_oe;
	endproperty
	a_hiz_hold: assert property (p_hiz_hold)
		else $error("pins driven before reconfiguration");

	// A map write ends the floating wait and drives the pins; a valid soft reset key restarts settling instead
	property p_hiz_release;
		@(posedge i_clk_sys) disable iff (i_reset)
		(state_reg == ST_HIZ && w_map_wr) |=> o_first_irq_pin_oe;
	endproperty
	a_hiz_release: assert property (p_hiz_release)
		else $error("pins not driven after reconfiguration");

	property p_init_read_zero;
		@(posedge i_clk_sys) disable iff (i_reset)
		(i_rd && w_in_init) |=> (o_rdata == 8'h00);
	endproperty
	a_init_read_zero: assert property (p_init_read_zero)
		else $error("read during settling not zero");

endmodule : ipr_router

`default_nettype wire

// *** sim/ipr_host_model.sv ***
// Host side model that watches the first interrupt pin
`timescale 1ns/1ps
`default_nettype none

module ipr_host_model (
	// Clock
	input  wire logic i_clk_sys,
	// Pin as the device presents it
	input  wire logic i_pin,
	input  wire logic i_pin_oe,
	// What the host sees on the wire
	output var  logic o_level,
	output var  logic o_driven
);
	// ==================================================================
	// Wire resolution
	logic last_reg; // Last level seen while driven

	// No pull is fitted, so a floating pin shows the inverse of its last level
	assign o_level  = i_pin_oe ? i_pin : ~last_reg;
	assign o_driven = i_pin_oe;

	// Remember the driven level
	always_ff @(posedge i_clk_sys) begin
		if (i_pin_oe) begin
			last_reg <= i_pin;
		end
	end
endmodule : ipr_host_model

`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the first interrupt pin event router
`timescale 1ns/1ps
`default_nettype none

// Compare, count and report
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_top;
	import ipr_pkg::*;

	// ==================================================================
	// Signals
	localparam int unsigned P_SRST = 8; // Short settle time keeps the run brief
	logic       clk_sys = 1'b0;
	logic       reset   = 1'b1;
	logic [7:0] addr    = 8'h00;
	logic [7:0] wdata   = 8'h00;
	logic       wr      = 1'b0;
	logic       rd      = 1'b0;
	logic [7:0] rdata;
	logic [7:0] src_lo  = 8'h00; // Bit 4 has no source
	logic [7:0] src_hi  = 8'h00;
	logic       pin, pin_oe, pin2, pin2_oe, busy;
	logic       host_level, host_driven;
	int         bad_count   = 0;
	int         checks_done = 0;
	int         busy_cnt    = 0; // Cycles seen with settling busy

	// ==================================================================
	// Clock and busy length counter
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (busy === 1'b1) begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	// ==================================================================
	// Device and host
	ipr_router #(.P_SRST_CYCLES(P_SRST)) u_ipr_router (
		.i_clk_sys(clk_sys), .i_reset(reset), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_fuse_busy_status(src_lo[7]), .i_idle(src_lo[6]), .i_motion(src_lo[5]),
		.i_queue_level(src_lo[3]), .i_queue_overflow(src_lo[2]),
		.i_queue_full(src_lo[1]), .i_sample_ready(src_lo[0]),
		.i_fuse_done_status(src_hi[7]), .i_fuse_request(src_hi[6]),
		.i_undervolt_latched(src_hi[5]), .i_clip_latched(src_hi[4]),
		.i_parity_fault(src_hi[3]), .i_tap3(src_hi[2]), .i_tap2(src_hi[1]),
		.i_tap1(src_hi[0]),
		.o_first_irq_pin(pin), .o_first_irq_pin_oe(pin_oe),
		.o_second_irq_pin(pin2), .o_second_irq_pin_oe(pin2_oe),
		.o_soft_reset_busy(busy));
	ipr_host_model u_ipr_host_model (.i_clk_sys(clk_sys), .i_pin(pin),
		.i_pin_oe(pin_oe), .o_level(host_level), .o_driven(host_driven));

	// ==================================================================
	// Register bus tasks, strobes one cycle wide
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : reg_wr

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : reg_rd

	// Set both maps and the sources, then look at the wire
	task automatic route_case(input logic [7:0] mlo, input logic [7:0] mhi,
		input logic [7:0] slo, input logic [7:0] shi, output logic lvl);
		reg_wr(ADDR_MAP0_LOW, mlo);
		reg_wr(ADDR_MAP0_HIGH, mhi);
		src_lo <= slo;
		src_hi <= shi;
		repeat (2) @(posedge clk_sys);
		#1;
		lvl = host_level;
	endtask : route_case

	// Bounded wait for the settling flag; a hang ends the run
	task automatic wait_busy(input logic lvl);
		#1;
		for (int n = 0; n < 50 && busy !== lvl; n++) begin
			@(posedge clk_sys);
			#1;
		end
		if (busy !== lvl) begin
			`CHK(busy, lvl)
			give_verdict();
		end
	endtask : wait_busy

	// ==================================================================
	// Scenarios
	// Hardware reset restores every map, pin stays driven
	task automatic t_reset_values;
		logic [7:0] d;
		@(posedge clk_sys);
		reset  <= 1'b1;
		src_lo <= 8'h00;
		src_hi <= 8'h00;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		reg_rd(ADDR_MAP0_LOW, d);
		`CHK(d, 8'h80)
		reg_rd(ADDR_MAP0_HIGH, d);
		`CHK(d, 8'h00)
		reg_rd(ADDR_MAP1_LOW, d);
		`CHK(d, 8'h00)
		// Queue full enable is active low, so it is routed out of reset
		@(posedge clk_sys);
		src_lo <= 8'h02;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK({host_driven, host_level}, 2'h3)
	endtask : t_reset_values

	// One low enable at a time; others blocked, high side all firing but off
	task automatic t_route_low;
		logic [7:0] en;
		logic       lvl;
		for (int b = 0; b < 8; b++) begin
			en = 8'h01 << b;
			if (b != 4) begin
				route_case(en ^ 8'h02, 8'h00, en, 8'h00, lvl);
				`CHK(lvl, 1'b1)
				route_case(en ^ 8'h02, 8'h00, ~en, 8'hFF, lvl);
				`CHK(lvl, 1'b0)
			end
		end
	endtask : t_route_low

	// One high enable at a time; low map fully disabled
	task automatic t_route_high;
		logic [7:0] en;
		logic       lvl;
		for (int b = 0; b < 8; b++) begin
			en = 8'h01 << b;
			route_case(8'h02, en, 8'hFF, en, lvl);
			`CHK(lvl, 1'b1)
			route_case(8'h02, en, 8'hFF, ~en, lvl);
			`CHK(lvl, 1'b0)
		end
	endtask : t_route_high

	// Read back, reserved bit 4 included; a wrong key does nothing
	task automatic t_regs;
		logic [7:0] d;
		reg_wr(ADDR_MAP0_LOW, 8'h5A);
		reg_wr(ADDR_MAP0_HIGH, 8'hA5);
		reg_wr(ADDR_MAP1_LOW, 8'h3C);
		reg_wr(ADDR_SOFT_RESET, 8'h02);
		reg_rd(ADDR_MAP0_LOW, d);
		`CHK(d, 8'h5A)
		reg_rd(ADDR_MAP0_HIGH, d);
		`CHK(d, 8'hA5)
		reg_rd(ADDR_MAP1_LOW, d);
		`CHK(d, 8'h3C)
		`CHK(host_driven, 1'b1)
		// Write then read with no gap between the strobes
		@(posedge clk_sys);
		addr  <= ADDR_MAP1_LOW;
		wdata <= 8'hC3;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		`CHK(rdata, 8'hC3)
		// Read data stands one cycle only
		@(posedge clk_sys);
		#1;
		`CHK(rdata, 8'h00)
	endtask : t_regs

	// Soft reset: pins float, reads blank, maps restored, release on write
	task automatic t_soft_reset;
		logic [7:0] d;
		reg_wr(ADDR_MAP0_LOW, 8'h00);
		reg_wr(ADDR_MAP0_HIGH, 8'hFF);
		busy_cnt = 0;
		reg_wr(ADDR_SOFT_RESET, 8'h52);
		wait_busy(1'b1);
		`CHK({host_driven, pin2_oe}, 2'h0)
		// Low map holds 0x80 now, so a blank read is told apart
		reg_rd(ADDR_MAP0_LOW, d);
		`CHK(d, 8'h00)
		wait_busy(1'b0);
		`CHK(busy_cnt, P_SRST)
		`CHK(host_driven, 1'b0)
		reg_rd(ADDR_MAP0_LOW, d);
		`CHK(d, 8'h80)
		reg_rd(ADDR_MAP0_HIGH, d);
		`CHK(d, 8'h00)
		reg_wr(ADDR_MAP1_LOW, 8'h00);
		@(posedge clk_sys);
		#1;
		`CHK({host_driven, pin2_oe, pin2}, 3'h6)
	endtask : t_soft_reset

	// ==================================================================
	// Verdict and main sequence
	task automatic give_verdict;
		if (bad_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset_values();
		t_route_low();
		t_route_high();
		t_regs();
		t_reset_values();
		t_soft_reset();
		give_verdict();
	end
endmodule : tb_top

`default_nettype wire
